// file: verification/wsfc_flow_sva.sv
`timescale 1ns/10ps
module wsfc_flow_sva #(
   parameter int SAMPLE_W = 16
) (
   // Clock and reset
   input wire logic                i_ref_clk,
   input wire logic                i_rst_n,
   // Register bus
   input wire logic [7:0]          i_avs_address,
   input wire logic                i_avs_read,
   input wire logic                i_avs_write,
   input wire logic [31:0]         i_avs_writedata,
   input wire logic [3:0]          i_avs_byteenable,
   input wire logic [31:0]         o_avs_readdata,
   input wire logic                o_avs_waitrequest,
   // Pins and samples
   input wire logic                i_trig_gate,
   input wire logic                i_enable,
   input wire logic                i_adv_event,
   input wire logic [SAMPLE_W-1:0] o_sample,
   input wire logic                o_sample_valid,
   input wire logic                o_playing
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);
   logic wr_ok;
   logic run_w;
   logic abort_w;
   assign wr_ok   = i_avs_write & ~o_avs_waitrequest & (i_avs_address == 8'h00) & i_avs_byteenable[0];
   assign run_w   = wr_ok & i_avs_writedata[0] & ~i_avs_writedata[1];
   assign abort_w = wr_ok & i_avs_writedata[1];

   bus_answer_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
      else $error("waitrequest did not drop after a request");
   wait_pulse_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   unmapped_zero_a: assert property (i_avs_read && !o_avs_waitrequest && i_avs_address > 8'h0C |->
      o_avs_readdata == 32'h0000_0000) else $error("unmapped read not zero");
   idle_offset_a: assert property (!o_sample_valid |-> o_sample == '0)
      else $error("sample not at offset while idle");
   play_valid_a: assert property (o_playing |-> o_sample_valid)
      else $error("playing without a run");
   offset_first_a: assert property ($rose(o_playing) |-> $past(o_sample_valid))
      else $error("playback began without offset first");
   run_offset_a: assert property (run_w && !o_sample_valid |-> ##[1:3] (o_sample_valid && o_sample == '0))
      else $error("run did not give offset sample");
   abort_stop_a: assert property (abort_w |-> ##[1:3] (!o_sample_valid && !o_playing))
      else $error("abort did not stop playback");
   hold_still_a: assert property (o_sample_valid && !o_playing |=>
      o_playing || !o_sample_valid || $stable(o_sample)) else $error("held sample moved");
   ramp_step_a: assert property (o_playing && $past(o_playing) |->
      o_sample[11:0] == $past(o_sample[11:0]) + 12'h001 || o_sample[11:0] == 12'h000)
      else $error("ramp skipped a sample");

   cover property (run_w);
   cover property ($rose(o_playing));
   cover property (abort_w && o_playing);
   cover property ($fell(o_playing) && o_sample_valid);
endmodule
bind wsfc_flow wsfc_flow_sva #(.SAMPLE_W(SAMPLE_W)) u_sva (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
   .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
   .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
   .o_avs_waitrequest(o_avs_waitrequest), .i_trig_gate(i_trig_gate), .i_enable(i_enable),
   .i_adv_event(i_adv_event), .o_sample(o_sample), .o_sample_valid(o_sample_valid), .o_playing(o_playing));

// file: verification/wsfc_flow_tb.sv
`timescale 1ns/10ps
module wsfc_flow_tb;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rq;
   logic [31:0] seed = 32'h842DBC19;
   logic        trig_req = 1'b0;
   logic        gate_lvl = 1'b0;
   logic        en_lvl = 1'b0;
   logic        evt_req = 1'b0;
   wire  [31:0] rdata;
   wire  [15:0] sample;
   wire         wait_r, tg, en, ev, valid, playing;
   int          fails, checks_done, cyc, n, n1, mx, len, ex;

   always #12.5 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         end_sim();
      end
   end

   wsfc_flow #(.SAMPLE_W(16)) u_dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_avs_address(addr), .i_avs_read(rd),
      .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hF), .o_avs_readdata(rdata),
      .o_avs_waitrequest(wait_r), .i_trig_gate(tg), .i_enable(en), .i_adv_event(ev), .o_sample(sample),
      .o_sample_valid(valid), .o_playing(playing));
   wsfc_pins u_pins (.i_ref_clk(clk), .i_trig_req(trig_req), .i_gate_lvl(gate_lvl), .i_en_lvl(en_lvl),
      .i_evt_req(evt_req), .o_trig_gate(tg), .o_enable(en), .o_adv_event(ev));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Expected playing cycles; -1 means endless
   function automatic int model_play(input int adv, input int l, input int loops);
      case (adv)
         1: return -1;
         3: return 2 * l;
         default: return l * loops;
      endcase
   endfunction
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= w;
      rd <= !w;
      // No fixed latency assumed; only the cycle ceiling ends a hung wait
      do begin
         @(posedge clk);
      end while (wait_r !== 1'b0);
      rq = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task automatic cfg(input logic [31:0] m, input logic [31:0] s);
      bus(1'b1, 8'h04, m);
      bus(1'b1, 8'h08, s);
      bus(1'b0, 8'h04, 32'h0);
      chk("mode", rq, m);
      bus(1'b0, 8'h08, 32'h0);
      chk("seg", rq, s);
   endtask
   task automatic win(input int w, input int ea = -1, input int eb = -1);
      n = 0;
      mx = 0;
      for (int i = 0; i < w; i++) begin
         @(posedge clk);
         evt_req <= (i == ea || i == eb);
         if (playing === 1'b1) n++;
         if (valid === 1'b1 && int'(sample[15:12]) > mx) mx = int'(sample[15:12]);
      end
   endtask
   task automatic trig();
      @(posedge clk);
      trig_req <= 1'b1;
      @(posedge clk);
      trig_req <= 1'b0;
   endtask
   task automatic end_sim();
      if (fails == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      bus(1'b0, 8'h04, 32'h0);
      chk("mode_rst", rq, 32'h0000_0100);
      bus(1'b0, 8'h08, 32'h0);
      chk("seg_rst", rq, 32'h0001_0010);
      bus(1'b0, 8'h40, 32'h0);
      chk("unmapped", rq, 32'h0);
      cfg(32'h0000_0100, 32'h0001_0008);
      win(30);
      chk("early_play", n, 0);
      bus(1'b1, 8'h00, 32'h1);
      win(100);
      chk("cont_play", playing, 1'b1);
      bus(1'b1, 8'h00, 32'h2);
      repeat (4) @(posedge clk);
      chk("abort_valid", valid, 1'b0);
      // Triggered, every advancement mode, random segment length
      for (int adv = 0; adv < 4; adv++) begin
         seed = lfsr(seed);
         len = 4 + int'(seed % 5);
         cfg({6'h00, 2'(adv), 8'h03, 16'(len)}, 32'h0);
         cfg(32'h0000_0104, {6'h00, 2'(adv), 8'h03, 16'(len)});
         bus(1'b1, 8'h00, 32'h1);
         win(20);
         chk("wait_trig", n, 0);
         chk("offset", {valid, sample}, 32'h0001_0000);
         trig();
         win(200, 2, 100);
         ex = model_play(adv, len, 3);
         if (ex < 0) chk("cond_play", playing, 1'b1);
         else chk("play_cnt", n, ex);
         if (adv % 2 == 0) chk("held", sample, len - 1);
         bus(1'b1, 8'h00, 32'h2);
         repeat (4) @(posedge clk);
         chk("stop_offset", {valid, sample}, 32'h0);
      end
      cfg(32'h0000_0108, 32'h0002_0006);
      bus(1'b1, 8'h00, 32'h1);
      gate_lvl <= 1'b1;
      win(60);
      n1 = n;
      gate_lvl <= 1'b0;
      win(100);
      chk("gate_play", n1 >= 50, 1'b1);
      chk("gate_hold", {playing, sample}, 32'h5);
      bus(1'b1, 8'h00, 32'h2);
      cfg(32'h0000_0106, 32'h0001_0006);
      bus(1'b1, 8'h00, 32'h1);
      trig();
      win(60);
      chk("no_enable", n, 0);
      bus(1'b1, 8'h00, 32'h2);
      en_lvl <= 1'b1;
      bus(1'b1, 8'h00, 32'h1);
      trig();
      win(8);
      n1 = n;
      en_lvl <= 1'b0;
      win(60);
      chk("enable_once", n1 + n, 6);
      bus(1'b1, 8'h00, 32'h2);
      cfg(32'h0000_0203, 32'h0001_0004);
      bus(1'b1, 8'h00, 32'h1);
      win(60);
      chk("first_loop", mx, 0);
      en_lvl <= 1'b1;
      win(60);
      chk("seq_on", mx, 1);
      en_lvl <= 1'b0;
      bus(1'b1, 8'h00, 32'h2);
      bus(1'b1, 8'h00, 32'h1);
      win(60);
      chk("restart_loop", mx, 0);
      bus(1'b1, 8'h00, 32'h2);
      // Triggered sequence of two conditional segments: only a stored event moves on
      cfg(32'h0000_0205, 32'h0101_0004);
      bus(1'b1, 8'h00, 32'h1);
      trig();
      win(40);
      chk("cond_stay", mx, 0);
      win(60, 5);
      chk("cond_next", mx, 1);
      bus(1'b0, 8'h0C, 32'h0);
      chk("status", rq[15:0], 16'h0013);
      bus(1'b1, 8'h00, 32'h2);
      cfg(32'h0000_0201, 32'h0001_0004);
      bus(1'b1, 8'h00, 32'h1);
      win(60);
      chk("seq_auto", mx, 1);
      end_sim();
   end
endmodule

// file: verification/wsfc_pins.sv
`timescale 1ns/10ps
module wsfc_pins (
   // Bench requests
   input  wire logic i_ref_clk,
   input  wire logic i_trig_req,
   input  wire logic i_gate_lvl,
   input  wire logic i_en_lvl,
   input  wire logic i_evt_req,
   // Pins toward the sequencer
   output wire logic o_trig_gate,
   output wire logic o_enable,
   output wire logic o_adv_event
);
   // Pulses stretched so the 3-stage synchroniser cannot miss them
   logic [2:0] trig_cnt = 3'h0;
   logic [2:0] evt_cnt  = 3'h0;
   always @(posedge i_ref_clk) begin
      if (i_trig_req) trig_cnt <= 3'h4;
      else if (trig_cnt != 3'h0) trig_cnt <= trig_cnt - 3'h1;
      if (i_evt_req) evt_cnt <= 3'h4;
      else if (evt_cnt != 3'h0) evt_cnt <= evt_cnt - 3'h1;
   end
   assign o_trig_gate = i_gate_lvl | (trig_cnt != 3'h0);
   assign o_enable    = i_en_lvl;
   assign o_adv_event = evt_cnt != 3'h0;
endmodule

// file: verilog/wsfc_flow.sv
// The implementer's own choices: register access over Avalon-MM and the address map.
`timescale 1ns/10ps
`include "wsfc_regs.svh"
module wsfc_flow
   import wsfc_pkg::*;
#(
   parameter int SAMPLE_W = 16
) (
   // Clock and reset
   input  wire logic                i_ref_clk,
   input  wire logic                i_rst_n,
   // Avalon-MM slave
   input  wire logic [7:0]          i_avs_address,
   input  wire logic                i_avs_read,
   input  wire logic                i_avs_write,
   input  wire logic [31:0]         i_avs_writedata,
   input  wire logic [3:0]          i_avs_byteenable,
   output logic      [31:0]         o_avs_readdata,
   output logic                     o_avs_waitrequest,
   // External control pins
   input  wire logic                i_trig_gate,
   input  wire logic                i_enable,
   input  wire logic                i_adv_event,
   // Sample datapath
   output logic      [SAMPLE_W-1:0] o_sample,
   output logic                     o_sample_valid,
   output logic                     o_playing
);

   typedef struct packed {
      logic [31:0]         rdata;
      logic                wait_n;
      logic [31:0]         mode;
      logic [31:0]         seg;
      logic [2:0]          s_tg;
      logic [2:0]          s_en;
      logic [2:0]          s_ev;
      logic                sw_trig;
      logic                sw_en;
      logic                sw_ev;
      logic                ev_pend;
      logic                en_seen;
      logic                gate_fell;
      logic                first_pass;
      wsfc_state_t         st;
      logic [3:0]          seg_idx;
      logic [7:0]          loop_cnt;
      logic [15:0]         addr;
      logic [SAMPLE_W-1:0] sample;
      logic                valid;
      logic                playing;
   } wsfc_state_s_t;

   wsfc_state_s_t r;
   wsfc_state_s_t next_r;

   // Midpoint of the signed code range, worked out signed so it lands on zero;
   // unsigned arithmetic here would land on the top code instead
   localparam logic [SAMPLE_W-1:0] OFFSET_CODE =
      SAMPLE_W'(($signed(`WSFC_DAC_MAX) + $signed(`WSFC_DAC_MIN)) / `WSFC_OFFSET_DIV);

   function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            res[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      return res;
   endfunction

   // Synthetic waveform: segment index and address give the sample
   function automatic logic [SAMPLE_W-1:0] wave(input logic [3:0] idx, input logic [15:0] a);
      return SAMPLE_W'({idx, a[11:0]});
   endfunction

   // Edge of a synchronised pin: stage 2 against stage 3
   function automatic logic rise_of(input logic [2:0] s);
      return s[1] & ~s[2];
   endfunction

   function automatic logic fall_of(input logic [2:0] s);
      return ~s[1] & s[2];
   endfunction

   // Next segment, back to the first after the last one
   function automatic logic [3:0] seg_after(input logic [3:0] idx, input logic [3:0] last);
      logic [3:0] res;
      if (idx == last) begin
         res = 4'h0;
      end else begin
         res = idx + 4'h1;
      end
      return res;
   endfunction

   // Write-one command on CTRL; only byte lane 0 carries commands
   function automatic logic ctrl_cmd(input logic hit, input logic [3:0] be, input logic [31:0] wd,
                                     input int pos);
      return hit & be[0] & wd[pos];
   endfunction

   // STATUS word: loop count, segment, stored event, enable, playing, running
   function automatic logic [31:0] status_word(input wsfc_state_s_t s);
      logic [31:0] res;
      res       = 32'h0000_0000;
      res[15:8] = s.loop_cnt;
      res[7:4]  = s.seg_idx;
      res[3]    = s.ev_pend;
      res[2]    = s.en_seen;
      res[1]    = s.playing;
      res[0]    = s.st != WSFC_ST_PROG;
      return res;
   endfunction

   wsfc_trig_t  trig_mode;
   wsfc_adv_t   adv_mode;
   wsfc_adv_t   elem_mode;
   logic        armed;
   logic        seq_mode;
   logic [3:0]  nseg;
   logic [15:0] seg_len;
   logic [7:0]  seg_loops;
   logic        tg_rise;
   logic        tg_fall;
   logic        en_now;
   logic        ev_in;
   logic        acc;
   logic        wr_ctrl;

   // Decoded CTRL commands
   logic        run_cmd;
   logic        abort_cmd;

   always_comb begin
      trig_mode = wsfc_trig_t'(r.mode[`WSFC_MODE_TRIG_HI:`WSFC_MODE_TRIG_LO]);
      elem_mode = wsfc_adv_t'(r.mode[`WSFC_MODE_ELEM_HI:`WSFC_MODE_ELEM_LO]);
      adv_mode  = wsfc_adv_t'(r.seg[`WSFC_SEG_ADV_HI:`WSFC_SEG_ADV_LO]);
      armed     = r.mode[`WSFC_MODE_ARMED];
      seq_mode  = r.mode[`WSFC_MODE_SEQ];
      nseg      = r.mode[`WSFC_MODE_NSEG_HI:`WSFC_MODE_NSEG_LO];
      seg_len   = r.seg[`WSFC_SEG_LEN_HI:`WSFC_SEG_LEN_LO];
      seg_loops = r.seg[`WSFC_SEG_LOOP_HI:`WSFC_SEG_LOOP_LO];
      // Only stage 2 and 3 are read; stage 1 is the metastable catch
      tg_rise   = rise_of(r.s_tg) | r.sw_trig;
      tg_fall   = fall_of(r.s_tg);
      en_now    = r.s_en[1] | r.sw_en;
      ev_in     = rise_of(r.s_ev) | r.sw_ev;
      acc       = ~r.wait_n & (i_avs_read | i_avs_write);
      wr_ctrl   = acc & i_avs_write & (i_avs_address == `WSFC_CTRL_ADDR);
      run_cmd   = ctrl_cmd(wr_ctrl, i_avs_byteenable, i_avs_writedata, `WSFC_CTRL_RUN);
      abort_cmd = ctrl_cmd(wr_ctrl, i_avs_byteenable, i_avs_writedata, `WSFC_CTRL_ABORT);
   end

   always_comb begin
      logic [3:0] last_seg;
      logic       elem_end;
      logic       last_loop;
      logic       wrap;
      logic       hold_first;
      last_seg   = seq_mode ? nseg - 4'h1 : 4'h0;
      elem_end   = 1'b0;
      last_loop  = 1'b0;
      wrap       = 1'b0;
      hold_first = 1'b0;
      next_r     = r;

      // Single-cycle answer: waitrequest drops for exactly one cycle per access
      next_r.wait_n  = acc;
      next_r.rdata   = 32'h0000_0000;
      next_r.sw_trig = 1'b0;
      next_r.sw_en   = 1'b0;
      next_r.sw_ev   = 1'b0;
      if (acc && i_avs_write) begin
         unique case (i_avs_address)
            `WSFC_MODE_ADDR: next_r.mode = merge_be(r.mode, i_avs_writedata, i_avs_byteenable);
            `WSFC_SEG_ADDR:  next_r.seg  = merge_be(r.seg, i_avs_writedata, i_avs_byteenable);
            default: ;
         endcase
      end
      if (acc && i_avs_read) begin
         unique case (i_avs_address)
            `WSFC_CTRL_ADDR:   next_r.rdata = 32'h0000_0000;
            `WSFC_MODE_ADDR:   next_r.rdata = r.mode;
            `WSFC_SEG_ADDR:    next_r.rdata = r.seg;
            `WSFC_STATUS_ADDR: next_r.rdata = status_word(r);
            default:           next_r.rdata = 32'h0000_0000;
         endcase
      end
      if (wr_ctrl && i_avs_byteenable[0]) begin
         next_r.sw_trig = i_avs_writedata[`WSFC_CTRL_SW_TRIG];
         next_r.sw_en   = i_avs_writedata[`WSFC_CTRL_SW_ENABLE];
         next_r.sw_ev   = i_avs_writedata[`WSFC_CTRL_SW_EVENT];
      end

      next_r.s_tg = {r.s_tg[1:0], i_trig_gate};
      next_r.s_en = {r.s_en[1:0], i_enable};
      next_r.s_ev = {r.s_ev[1:0], i_adv_event};

      if (ev_in) begin
         next_r.ev_pend = 1'b1;
      end
      if (tg_fall && trig_mode == WSFC_TRIG_GATED) begin
         next_r.gate_fell = 1'b1;
      end

      // Armed continuous: enable may arrive any time while first element loops
      if (en_now && r.st == WSFC_ST_PLAY && r.first_pass) begin
         next_r.en_seen = 1'b1;
      end

      elem_end  = r.addr == seg_len - 16'h1;
      last_loop = r.loop_cnt == seg_loops - 8'h1;

      unique case (r.st)
         WSFC_ST_PROG: begin
            next_r.sample  = OFFSET_CODE;
            next_r.valid   = 1'b0;
            next_r.playing = 1'b0;
            if (run_cmd) begin
               next_r.st = WSFC_ST_OFFSET;
            end
         end
         WSFC_ST_OFFSET: begin
            next_r.sample     = OFFSET_CODE;
            next_r.valid      = 1'b1;
            next_r.playing    = 1'b0;
            next_r.seg_idx    = 4'h0;
            next_r.loop_cnt   = 8'h00;
            next_r.addr       = 16'h0000;
            next_r.first_pass = 1'b1;
            next_r.gate_fell  = 1'b0;
            next_r.en_seen    = 1'b0;
            if (trig_mode == WSFC_TRIG_CONT) begin
               next_r.st = WSFC_ST_WAIT_EVT;
            end else if (tg_rise && (!armed || en_now)) begin
               // Enable looked at only here, at the start
               next_r.st = WSFC_ST_WAIT_EVT;
            end
         end
         WSFC_ST_WAIT_EVT: begin
            // Single waits before every pass except while an armed first element is held; others go straight on.
            // Output pauses here, so o_playing drops between passes
            next_r.playing = 1'b0;
            if (adv_mode != WSFC_ADV_SINGLE) begin
               next_r.st = WSFC_ST_PLAY;
            end else if (r.ev_pend) begin
               next_r.ev_pend = ev_in;
               next_r.st      = WSFC_ST_PLAY;
            end
         end
         WSFC_ST_PLAY: begin
            next_r.sample  = wave(r.seg_idx, r.addr);
            next_r.valid   = 1'b1;
            next_r.playing = 1'b1;
            next_r.addr    = r.addr + 16'h1;
            if (elem_end) begin
               next_r.addr     = 16'h0000;
               next_r.loop_cnt = r.loop_cnt + 8'h01;
               hold_first = armed && trig_mode == WSFC_TRIG_CONT && r.first_pass &&
                            r.seg_idx == 4'h0 && !(r.en_seen || en_now);
               if (hold_first) begin
                  next_r.loop_cnt = 8'h00;
               end else if (adv_mode == WSFC_ADV_COND ||
                            (trig_mode == WSFC_TRIG_GATED && !r.gate_fell && !seq_mode)) begin
                  next_r.loop_cnt = 8'h00;
                  // Conditional element moves on only on a stored event
                  if (seq_mode && adv_mode == WSFC_ADV_COND && r.ev_pend) begin
                     next_r.ev_pend = ev_in;
                     wrap = r.seg_idx == last_seg;
                     next_r.seg_idx = seg_after(r.seg_idx, last_seg);
                  end
               end else if (last_loop) begin
                  next_r.loop_cnt = 8'h00;
                  if (adv_mode == WSFC_ADV_REPEAT) begin
                     next_r.st = WSFC_ST_END_EVT;
                  end else begin
                     wrap = r.seg_idx == last_seg;
                     next_r.seg_idx = seg_after(r.seg_idx, last_seg);
                     next_r.first_pass = 1'b0;
                  end
               end
               if (adv_mode == WSFC_ADV_SINGLE && !hold_first) begin
                  next_r.st = WSFC_ST_WAIT_EVT;
               end
               if (wrap) begin
                  if (trig_mode == WSFC_TRIG_CONT) begin
                     next_r.first_pass = 1'b1;
                     next_r.en_seen    = 1'b0;
                  end else if (trig_mode == WSFC_TRIG_GATED && !r.gate_fell) begin
                     next_r.st = WSFC_ST_WAIT_EVT;
                  end else begin
                     next_r.st = WSFC_ST_HOLD;
                  end
               end
            end
         end
         WSFC_ST_END_EVT: begin
            // Last sample stands until an event has been stored
            next_r.playing = 1'b0;
            if (r.ev_pend) begin
               next_r.ev_pend = ev_in;
               wrap = r.seg_idx == last_seg;
               next_r.seg_idx    = seg_after(r.seg_idx, last_seg);
               next_r.first_pass = 1'b0;
               if (!wrap) begin
                  next_r.st = WSFC_ST_WAIT_EVT;
               end else if (trig_mode == WSFC_TRIG_CONT) begin
                  next_r.st = WSFC_ST_WAIT_EVT;
                  next_r.first_pass = 1'b1;
               end else begin
                  next_r.st = WSFC_ST_HOLD;
               end
            end
         end
         WSFC_ST_HOLD: begin
            // Last sample stays in o_sample
            next_r.playing = 1'b0;
         end
      endcase

      // Abort wins over everything, mid-element
      // A fresh RUN is needed to leave programming again
      if (abort_cmd) begin
         next_r.st      = WSFC_ST_PROG;
         next_r.sample  = OFFSET_CODE;
         next_r.playing = 1'b0;
         next_r.valid   = 1'b0;
         next_r.ev_pend = 1'b0;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         r         <= '0;
         r.mode    <= `WSFC_MODE_RESET;
         r.seg     <= `WSFC_SEG_RESET;
         r.st      <= WSFC_ST_PROG;
         r.sample  <= OFFSET_CODE;
      end else begin
         r <= next_r;
      end
   end

   assign o_avs_readdata    = r.rdata;
   assign o_avs_waitrequest = ~r.wait_n;
   assign o_sample          = r.sample;
   assign o_sample_valid    = r.valid;
   assign o_playing         = r.playing;

endmodule

// file: verilog/wsfc_pkg.sv
package wsfc_pkg;

   typedef enum logic [1:0] {
      WSFC_TRIG_CONT,
      WSFC_TRIG_TRIGGERED,
      WSFC_TRIG_GATED
   } wsfc_trig_t;

   typedef enum logic [1:0] {
      WSFC_ADV_AUTO,
      WSFC_ADV_COND,
      WSFC_ADV_REPEAT,
      WSFC_ADV_SINGLE
   } wsfc_adv_t;

   typedef enum {
      WSFC_ST_PROG,
      WSFC_ST_OFFSET,
      WSFC_ST_WAIT_EVT,
      WSFC_ST_PLAY,
      WSFC_ST_END_EVT,
      WSFC_ST_HOLD
   } wsfc_state_t;

endpackage

// file: verilog/wsfc_regs.svh
`ifndef WSFC_REGS_SVH
`define WSFC_REGS_SVH

// Register byte addresses (one 32-bit word each)
`define WSFC_CTRL_ADDR       8'h00
`define WSFC_MODE_ADDR       8'h04
`define WSFC_SEG_ADDR        8'h08
`define WSFC_STATUS_ADDR     8'h0C

// CTRL fields: write-one pulses
`define WSFC_CTRL_RUN        0
`define WSFC_CTRL_ABORT      1
`define WSFC_CTRL_SW_TRIG    2
`define WSFC_CTRL_SW_EVENT   3
`define WSFC_CTRL_SW_ENABLE  4

// MODE fields
`define WSFC_MODE_SEQ        0
`define WSFC_MODE_ARMED      1
`define WSFC_MODE_TRIG_LO    2
`define WSFC_MODE_TRIG_HI    3
`define WSFC_MODE_ELEM_LO    4
`define WSFC_MODE_ELEM_HI    5
`define WSFC_MODE_NSEG_LO    8
`define WSFC_MODE_NSEG_HI    11
`define WSFC_MODE_RESET      32'h0000_0100

// SEG fields: common segment setup
`define WSFC_SEG_LEN_LO      0
`define WSFC_SEG_LEN_HI      15
`define WSFC_SEG_LOOP_LO     16
`define WSFC_SEG_LOOP_HI     23
`define WSFC_SEG_ADV_LO      24
`define WSFC_SEG_ADV_HI      25
`define WSFC_SEG_RESET       32'h0001_0010

// Sample code range
`define WSFC_DAC_MAX         16'h7FFF
`define WSFC_DAC_MIN         16'h8000
`define WSFC_OFFSET_DIV      2

`endif
